// ===== gafpc_pkg.sv
// Constants and types for the async fall detect and pad pull control block
package gafpc_pkg;

   // Pin counts and bus widths
   localparam int unsigned NUM_PINS  = 54;
   localparam int unsigned LOW_PINS  = 32;
   localparam int unsigned HIGH_PINS = 22;
   localparam int unsigned ADDR_W    = 5;
   localparam int unsigned DATA_W    = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_AFEN_LO = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_AFEN_HI = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_PULL    = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_PCLK_LO = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_PCLK_HI = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_EDS_LO  = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_EDS_HI  = 5'h18;

   // Field positions
   localparam int unsigned PULL_SEL_LSB = 0;
   localparam int unsigned PULL_SEL_W   = 2;
   localparam int unsigned HIGH_MSB     = 21;

   // Pull select encodings
   typedef enum logic [1:0] {
      GAFPC_PULL_OFF  = 2'h0,
      GAFPC_PULL_DOWN = 2'h1,
      GAFPC_PULL_UP   = 2'h2,
      GAFPC_PULL_RSVD = 2'h3
   } gafpc_pull_t;

   // Reset values
   localparam logic [DATA_W-1:0]   RST_AFEN = 32'h0000_0000;
   localparam logic [DATA_W-1:0]   RST_PCLK = 32'h0000_0000;
   localparam logic [PULL_SEL_W-1:0] RST_PULL = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_EDS  = 54'h0;

   // Pad pull state applied after a pad power cycle
   localparam logic [NUM_PINS-1:0] PAD_DFLT_UP = 54'h1FC01C000001FF;
   localparam logic [NUM_PINS-1:0] PAD_DFLT_DN = 54'h0FE3CFFFFE00;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Mask for the implemented bits of a high register
   localparam logic [DATA_W-1:0] HIGH_MASK = 32'h003F_FFFF;

endpackage : gafpc_pkg

// ===== gafpc_det_if.sv
// Carrier between the register core and the async fall detectors
`timescale 1ns/1ps
interface gafpc_det_if;
   import gafpc_pkg::*;

   logic [NUM_PINS-1:0] enable;
   logic [NUM_PINS-1:0] event_pulse;

   modport core (output enable, input event_pulse);
   modport det  (input enable, output event_pulse);

endinterface : gafpc_det_if

// ===== gafpc_fall_det.sv
// Per-pin asynchronous falling edge catchers with toggle synchronisers
`timescale 1ns/1ps
module gafpc_fall_det
   import gafpc_pkg::*;
(
   // System clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Pad levels
   input  wire logic [NUM_PINS-1:0] pad_in,
   // Link to the register core
   gafpc_det_if.det               dif
);

   logic [NUM_PINS-1:0] catch_tog_r;
   logic [NUM_PINS-1:0] sync1_r;
   logic [NUM_PINS-1:0] sync2_r;
   logic [NUM_PINS-1:0] sync3_r;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      logic tog_r;

      // The pin itself clocks the catcher, so glitches shorter than a
      // system clock period still flip the toggle
      always_ff @(negedge pad_in[i] or posedge rst) begin
         if (rst) begin
            tog_r <= 1'b0;
         end else if (dif.enable[i]) begin
            tog_r <= ~tog_r;
         end
      end

      assign catch_tog_r[i] = tog_r;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= catch_tog_r;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Enable gating again here drops an edge caught just before disable
   assign dif.event_pulse = (sync2_r ^ sync3_r) & dif.enable;

endmodule : gafpc_fall_det

// ===== gafpc_top.sv
// Async fall detect enables, event status and pad pull control over AXI4-Lite
//
// Notes on behaviour
// - Enabled pin falling edge sets its event detect status bit.
// - Disabled pins raise no async fall events; enables reset to zero.
// - Falling edge is caught by the pin itself, not clock sampled.
// - High enable register holds pins 32-53; bits 31-22 read zero.
// - Pull select: 00 off, 01 down, 10 up, 11 reserved; rest zero.
// - One shared pull line to all pads; pad latches on its clock.
// - Latched pad pull state cannot be read back; software remembers it.
// - Pads keep latched pull through core power-down and register loss.
// - After pad power-down each pad applies its default pull.
// - Only clocked pads take the new pull; others keep theirs.
// - Pad clock bit 1 clocks its pad; low and high register layout.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module gafpc_top
   import gafpc_pkg::*;
(
   // Clock and core reset
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // Pad power-on: reloads pad default pulls
   input  wire logic                pad_por,
   // AXI4-Lite write address
   input  wire logic                s_axi_awvalid,
   output      logic                s_axi_awready,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                s_axi_wvalid,
   output      logic                s_axi_wready,
   input  wire logic [DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // AXI4-Lite write response
   output      logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output      logic [1:0]          s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                s_axi_arvalid,
   output      logic                s_axi_arready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   // AXI4-Lite read data
   output      logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output      logic [DATA_W-1:0]   s_axi_rdata,
   output      logic [1:0]          s_axi_rresp,
   // Pads
   input  wire logic [NUM_PINS-1:0] pad_in,
   output      logic [1:0]          pull_ctrl_line,
   output      logic [NUM_PINS-1:0] pad_clk,
   output      logic [NUM_PINS-1:0] pad_pull_up,
   output      logic [NUM_PINS-1:0] pad_pull_dn
);

   // Merge write data into a register under the byte strobes
   function automatic logic [DATA_W-1:0] strb_merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0]        strb
   );
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : strb_merge

   // Expand byte strobes into a bit mask
   function automatic logic [DATA_W-1:0] strb_mask(
      input logic [3:0] strb
   );
      logic [DATA_W-1:0] res;
      res = '0;
      for (int b = 0; b < 4; b++) begin
         res[b*8 +: 8] = {8{strb[b]}};
      end
      return res;
   endfunction : strb_mask

   // True for an implemented register offset
   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] a
   );
      return (a == OFS_AFEN_LO) || (a == OFS_AFEN_HI) ||
             (a == OFS_PULL)    || (a == OFS_PCLK_LO) ||
             (a == OFS_PCLK_HI) || (a == OFS_EDS_LO)  ||
             (a == OFS_EDS_HI);
   endfunction : addr_hit

   // True when a committed write targets the given register
   function automatic logic wr_hit(
      input logic              go,
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs
   );
      return go && (a == ofs);
   endfunction : wr_hit

   // Register state
   logic [DATA_W-1:0]     afen_lo_r;
   logic [DATA_W-1:0]     afen_hi_r;
   logic [PULL_SEL_W-1:0] pull_sel_r;
   logic [DATA_W-1:0]     pclk_lo_r;
   logic [DATA_W-1:0]     pclk_hi_r;
   logic [NUM_PINS-1:0]   eds_r;
   logic [NUM_PINS-1:0]   eds_nxt;

   // Pad side state, untouched by the core reset
   logic [NUM_PINS-1:0]   pad_up_r;
   logic [NUM_PINS-1:0]   pad_dn_r;

   // Write channel holding
   logic                  aw_full_r;
   logic                  w_full_r;
   logic [ADDR_W-1:0]     waddr_r;
   logic [DATA_W-1:0]     wdata_r;
   logic [3:0]            wstrb_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  do_write;

   // Read channel
   logic                  rvalid_r;
   logic [DATA_W-1:0]     rdata_r;
   logic [1:0]            rresp_r;
   logic [DATA_W-1:0]     rd_val;

   // Event clear strobes from software
   logic [NUM_PINS-1:0]   eds_clr;
   logic [DATA_W-1:0]     clr_mask;

   // Pad clock edge finder
   logic [NUM_PINS-1:0]   pclk_prev_r;
   logic [NUM_PINS-1:0]   pclk_rise;

   gafpc_det_if dif ();

   assign dif.enable = {afen_hi_r[HIGH_MSB:0], afen_lo_r};

   gafpc_fall_det u_det (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pad_in  (pad_in),
      .dif     (dif)
   );

   // ---------------- Write channel ----------------
   assign s_axi_awready = !aw_full_r && !bvalid_r;
   assign s_axi_wready  = !w_full_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // Write commits one cycle after both halves are held
   assign do_write = aw_full_r && w_full_r && !bvalid_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_full_r <= 1'b0;
         waddr_r   <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_r <= 1'b1;
         waddr_r   <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         w_full_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
         w_full_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= addr_hit(waddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ---------------- Registers ----------------
   // One process per register, so a decode slip hits one register only
   // instead of hiding behind a priority chain
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         afen_lo_r <= RST_AFEN;
      end else if (wr_hit(do_write, waddr_r, OFS_AFEN_LO)) begin
         afen_lo_r <= strb_merge(afen_lo_r, wdata_r, wstrb_r);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         afen_hi_r <= RST_AFEN;
      end else if (wr_hit(do_write, waddr_r, OFS_AFEN_HI)) begin
         afen_hi_r <= strb_merge(afen_hi_r, wdata_r, wstrb_r)
                      & HIGH_MASK;
      end
   end

   // Only byte lane 0 carries the field; other lanes are dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pull_sel_r <= RST_PULL;
      end else if (wr_hit(do_write, waddr_r, OFS_PULL) && wstrb_r[0]) begin
         pull_sel_r <= wdata_r[PULL_SEL_LSB +: PULL_SEL_W];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pclk_lo_r <= RST_PCLK;
      end else if (wr_hit(do_write, waddr_r, OFS_PCLK_LO)) begin
         pclk_lo_r <= strb_merge(pclk_lo_r, wdata_r, wstrb_r);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pclk_hi_r <= RST_PCLK;
      end else if (wr_hit(do_write, waddr_r, OFS_PCLK_HI)) begin
         pclk_hi_r <= strb_merge(pclk_hi_r, wdata_r, wstrb_r)
                      & HIGH_MASK;
      end
   end

   // Event status: write one to clear, a new event in the same cycle wins
   assign clr_mask = wdata_r & strb_mask(wstrb_r);

   always_comb begin
      eds_clr = '0;
      if (wr_hit(do_write, waddr_r, OFS_EDS_LO)) begin
         eds_clr[LOW_PINS-1:0] = clr_mask;
      end
      if (wr_hit(do_write, waddr_r, OFS_EDS_HI)) begin
         eds_clr[NUM_PINS-1:LOW_PINS] = clr_mask[HIGH_MSB:0];
      end
      eds_nxt = (eds_r & ~eds_clr) | dif.event_pulse;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eds_r <= RST_EDS;
      end else begin
         eds_r <= eds_nxt;
      end
   end

   // ---------------- Pad drive ----------------
   // The shared line is the register itself, so set-up and hold are
   // purely a matter of software timing
   assign pull_ctrl_line = pull_sel_r;
   assign pad_clk = {pclk_hi_r[HIGH_MSB:0], pclk_lo_r};

   // Pads latch on the rising edge of their clock only: software puts
   // the pull line back before it drops the clock, and a level latch
   // would then overwrite the pull it has just set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pclk_prev_r <= '0;
      end else begin
         pclk_prev_r <= pad_clk;
      end
   end

   assign pclk_rise = pad_clk & ~pclk_prev_r;

   // Pads sit in the always-on domain: only the pad power-on reloads
   // them, a core reset leaves the latched pulls alone
   always_ff @(posedge sys_clk) begin
      if (pad_por) begin
         pad_up_r <= PAD_DFLT_UP;
         pad_dn_r <= PAD_DFLT_DN;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (pclk_rise[i]) begin
               pad_up_r[i] <= (pull_ctrl_line == GAFPC_PULL_UP);
               pad_dn_r[i] <= (pull_ctrl_line == GAFPC_PULL_DOWN);
            end
         end
      end
   end

   assign pad_pull_up = pad_up_r;
   assign pad_pull_dn = pad_dn_r;

   // ---------------- Read channel ----------------
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // Pad latched pulls have no read path; software must track them
   always_comb begin
      unique case (s_axi_araddr)
         OFS_AFEN_LO: rd_val = afen_lo_r;
         OFS_AFEN_HI: rd_val = afen_hi_r & HIGH_MASK;
         OFS_PULL:    rd_val = {{(DATA_W-PULL_SEL_W){1'b0}},
                                pull_sel_r};
         OFS_PCLK_LO: rd_val = pclk_lo_r;
         OFS_PCLK_HI: rd_val = pclk_hi_r & HIGH_MASK;
         OFS_EDS_LO:  rd_val = eds_r[LOW_PINS-1:0];
         OFS_EDS_HI:  rd_val = {{(DATA_W-HIGH_PINS){1'b0}},
                                eds_r[NUM_PINS-1:LOW_PINS]};
         default:     rd_val = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_val;
         rresp_r  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule : gafpc_top

// ===== gafpc_pad_model.sv
// Behavioural pads: idle-high inputs with short falling glitches on demand
`timescale 1ns/1ps
module gafpc_pad_model
   import gafpc_pkg::*;
(
   // Pad levels seen by the block
   output logic [NUM_PINS-1:0] pad_in
);
   initial pad_in = '1;

   // Low for a fraction of a clock period, so a sampled catcher would miss it
   task automatic glitch(input logic [NUM_PINS-1:0] m);
      pad_in = pad_in & ~m;
      #2;
      pad_in = pad_in | m;
   endtask : glitch
endmodule : gafpc_pad_model

// ===== gafpc_top_asserts.sv
// Concurrent checks on pad pull outputs and register read data
`timescale 1ns/1ps
module gafpc_top_asserts
   import gafpc_pkg::*;
(
   // Clock and resets
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire logic                pad_por,
   // Read channel
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [ADDR_W-1:0]   s_axi_araddr,
   input wire logic                s_axi_rvalid,
   input wire logic [DATA_W-1:0]   s_axi_rdata,
   // Pads
   input wire logic [1:0]          pull_ctrl_line,
   input wire logic [NUM_PINS-1:0] pad_clk,
   input wire logic [NUM_PINS-1:0] pad_pull_up,
   input wire logic [NUM_PINS-1:0] pad_pull_dn
);
   logic [ADDR_W-1:0] rd_addr_r;

   always_ff @(posedge sys_clk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_r <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || pad_por);

   sequence s_up_strobe;
      $rose(pad_clk[0]) && pull_ctrl_line == 2'h2;
   endsequence
   sequence s_dn_strobe;
      $rose(pad_clk[NUM_PINS-1]) && pull_ctrl_line == 2'h1;
   endsequence

   a_pad_takes_up: assert property (
      s_up_strobe |=> pad_pull_up[0] && !pad_pull_dn[0])
      else $error("pad 0 missed pull-up");
   a_pad_takes_dn: assert property (
      s_dn_strobe |=> pad_pull_dn[NUM_PINS-1] && !pad_pull_up[NUM_PINS-1])
      else $error("pad 53 missed pull-down");
   a_held_clk_keep: assert property (
      pad_clk[0] && $past(pad_clk[0]) |=> $stable(pad_pull_up[0]))
      else $error("pad 0 relatched on a held clock");
   a_unclocked_keep: assert property (
      1'b1 |=> (((pad_pull_up ^ $past(pad_pull_up))
      | (pad_pull_dn ^ $past(pad_pull_dn))) & ~$past(pad_clk)) == '0)
      else $error("unclocked pad changed pull");
   a_por_defaults: assert property (disable iff (1'b0)
      pad_por |=> pad_pull_up == PAD_DFLT_UP && pad_pull_dn == PAD_DFLT_DN)
      else $error("pad defaults not applied");
   a_core_rst_keep: assert property (disable iff (pad_por)
      rst && pad_clk == '0 |=> $stable(pad_pull_up) && $stable(pad_pull_dn))
      else $error("core reset disturbed pad pulls");
   a_clk_line_rst: assert property (disable iff (1'b0)
      rst |=> pad_clk == '0 && pull_ctrl_line == 2'h0)
      else $error("pad clock or pull line not reset");
   a_hi_enable_rsvd: assert property (
      s_axi_rvalid && rd_addr_r == OFS_AFEN_HI |-> s_axi_rdata[31:22] == '0)
      else $error("high enable reserved bits set");
   a_pull_rsvd: assert property (
      s_axi_rvalid && rd_addr_r == OFS_PULL |-> s_axi_rdata[31:2] == '0)
      else $error("pull select unused bits set");
   a_hi_clock_rsvd: assert property (
      s_axi_rvalid && rd_addr_r == OFS_PCLK_HI |-> s_axi_rdata[31:22] == '0)
      else $error("high pad clock reserved bits set");
endmodule : gafpc_top_asserts

bind gafpc_top gafpc_top_asserts gafpc_top_asserts_i (.*);

// ===== gafpc_top_tb.sv
// Self-checking bench: registers, pad pull sequence, async fall events
`timescale 1ns/1ps
module gafpc_top_tb;
   import gafpc_pkg::*;

   logic                sys_clk = 1'b0;
   logic                rst, pad_por;
   logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic                s_axi_arvalid, s_axi_rready;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic                s_axi_arready, s_axi_rvalid;
   logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp, pull_ctrl_line;
   logic [NUM_PINS-1:0] pad_in, pad_clk, pad_pull_up, pad_pull_dn;
   logic [NUM_PINS-1:0] exp_up, exp_dn;
   logic [31:0]         msk [5];
   int                  errors = 0;
   int                  check_count = 0;
   int                  cyc = 0;

   gafpc_top gafpc_top_i (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .*);
   gafpc_pad_model gafpc_pad_model_i (.pad_in(pad_in));

   always #5 sys_clk = ~sys_clk;

   // Ceiling well above the roughly 1100 cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         final_report();
      end
   end

   task automatic chk(input string n, input logic [63:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Handshakes are judged at the falling edge, where nothing moves
   task automatic wchk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [1:0] er);
      logic aw_h, w_h, b_ok;
      logic [1:0] r;
      b_ok = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!b_ok) begin
         @(negedge sys_clk);
         aw_h = s_axi_awvalid && s_axi_awready;
         w_h  = s_axi_wvalid && s_axi_wready;
         b_ok = s_axi_bvalid;
         r    = s_axi_bresp;
         @(posedge sys_clk);
         if (aw_h) s_axi_awvalid <= 1'b0;
         if (w_h) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
      chk("bresp", er, r);
   endtask : wchk

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      logic ar_h, r_ok;
      logic [31:0] d;
      logic [1:0] r;
      r_ok = 1'b0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!r_ok) begin
         @(negedge sys_clk);
         ar_h = s_axi_arvalid && s_axi_arready;
         r_ok = s_axi_rvalid;
         d    = s_axi_rdata;
         r    = s_axi_rresp;
         @(posedge sys_clk);
         if (ar_h) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
      chk("rdata", e, d);
      chk("rresp", er, r);
   endtask : rchk

   task automatic pull_seq(input logic [1:0] sel, input logic [31:0] lo, hi);
      logic [NUM_PINS-1:0] m;
      m = {hi[21:0], lo};
      wchk(OFS_PULL, {30'h0, sel}, RESP_OKAY);
      repeat (150) @(posedge sys_clk);
      wchk(OFS_PCLK_LO, lo, RESP_OKAY);
      wchk(OFS_PCLK_HI, hi, RESP_OKAY);
      repeat (150) @(posedge sys_clk);
      wchk(OFS_PULL, 32'h0, RESP_OKAY);
      wchk(OFS_PCLK_LO, 32'h0, RESP_OKAY);
      wchk(OFS_PCLK_HI, 32'h0, RESP_OKAY);
      exp_up = (exp_up & ~m) | (sel == 2'h2 ? m : '0);
      exp_dn = (exp_dn & ~m) | (sel == 2'h1 ? m : '0);
      chk("pad_pull_up", exp_up, pad_pull_up);
      chk("pad_pull_dn", exp_dn, pad_pull_dn);
   endtask : pull_seq

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report

   initial begin
      msk = '{32'hFFFF_FFFF, HIGH_MASK, 32'h3, 32'hFFFF_FFFF, HIGH_MASK};
      {rst, pad_por} = 2'h3;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb   = 4'hF;
      repeat (5) @(posedge sys_clk);
      rst     <= 1'b0;
      pad_por <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 5; i++) rchk(5'(4*i), 32'h0, RESP_OKAY);
      chk("pad default up", PAD_DFLT_UP, pad_pull_up);
      chk("pad default dn", PAD_DFLT_DN, pad_pull_dn);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         wchk(5'(4*i), 32'hFFFF_FFFF, RESP_OKAY);
         rchk(5'(4*i), msk[i], RESP_OKAY);
      end
      for (int i = 0; i < 5; i++) wchk(5'(4*i), 32'h0, RESP_OKAY);
      wchk(5'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
      rchk(5'h1C, 32'h0, RESP_SLVERR);
      exp_up = '0;
      exp_dn = '0;
      chk("pads after reserved code", 64'h0, pad_pull_up | pad_pull_dn);
      $display("register test done");
      pull_seq(2'h2, 32'h5, 32'h1);
      pull_seq(2'h1, 32'h0, 32'h0020_0000);
      pull_seq(2'h0, 32'h1, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("retained up", exp_up, pad_pull_up);
      chk("retained dn", exp_dn, pad_pull_dn);
      rchk(OFS_PULL, 32'h0, RESP_OKAY);
      $display("pull test done");
      wchk(OFS_AFEN_LO, 32'h20, RESP_OKAY);
      wchk(OFS_AFEN_HI, 32'h2, RESP_OKAY);
      @(negedge sys_clk);
      gafpc_pad_model_i.glitch(54'h2_0000_0060);
      repeat (6) @(posedge sys_clk);
      rchk(OFS_EDS_LO, 32'h20, RESP_OKAY);
      rchk(OFS_EDS_HI, 32'h2, RESP_OKAY);
      wchk(OFS_EDS_LO, 32'h20, RESP_OKAY);
      wchk(OFS_AFEN_LO, 32'h0, RESP_OKAY);
      @(negedge sys_clk);
      gafpc_pad_model_i.glitch(54'h20);
      repeat (6) @(posedge sys_clk);
      rchk(OFS_EDS_LO, 32'h0, RESP_OKAY);
      $display("event test done");
      final_report();
   end
endmodule : gafpc_top_tb
